// ===== pkg/clock_reset_pkg.sv
package clock_reset_pkg;

    // ------------------------------------------------------------
    // register byte addresses (index times four)
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_MAIN_CLOCK_CTRL = 8'h38;
    localparam logic [7:0] IDX_OSC_TRIM_HIGH = 8'h39;
    localparam logic [7:0] IDX_INTEGRITY = 8'h3A;
    localparam logic [7:0] IDX_PRESCALE_THRESH = 8'h3E;
    localparam logic [7:0] IDX_CLOCK_SWITCH = 8'h3F;
    localparam logic [9:0] ADDR_MAIN_CLOCK_CTRL = {IDX_MAIN_CLOCK_CTRL, 2'b00};
    localparam logic [9:0] ADDR_OSC_TRIM_HIGH = {IDX_OSC_TRIM_HIGH, 2'b00};
    localparam logic [9:0] ADDR_INTEGRITY = {IDX_INTEGRITY, 2'b00};
    localparam logic [9:0] ADDR_PRESCALE_THRESH = {IDX_PRESCALE_THRESH, 2'b00};
    localparam logic [9:0] ADDR_CLOCK_SWITCH = {IDX_CLOCK_SWITCH, 2'b00};
    // own register: slow-delay select and sequencer state
    localparam logic [9:0] ADDR_RESET_STATUS = 10'h100;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_MAIN_CLOCK_CTRL = 8'h00;
    localparam logic [7:0] RST_OSC_TRIM_HIGH = 8'hFF;
    localparam logic [1:0] RST_TRIM_LOWER = 2'h0;
    localparam logic [2:0] RST_PRESCALE = 3'h0;
    localparam logic [1:0] RST_THRESHOLD = 2'h3;
    localparam logic RST_SOURCE_SELECT = 1'b1;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int BIT_SLOW_DIVIDE = 0;
    localparam int BIT_CLOCK_OUT = 1;
    localparam int BIT_SRC_SELECT = 0;
    localparam int BIT_FAST_READY = 2;
    localparam int BIT_SLOW_READY = 3;
    localparam int BIT_UV_FLAG = 2;
    localparam int BIT_SW_FLAG = 1;
    localparam int BIT_SW_IRQ_EN = 0;
    localparam int LSB_TRIM_LOWER = 5;
    localparam int LSB_PRESCALE = 5;

    // ------------------------------------------------------------
    // prescaler codes and divisors
    // ------------------------------------------------------------
    localparam logic [2:0] PRE_DIV2 = 3'h1;
    localparam logic [2:0] PRE_DIV4 = 3'h2;
    localparam logic [2:0] PRE_DIV8 = 3'h3;
    localparam logic [2:0] PRE_DIV16 = 3'h4;
    localparam int SLOW_DIVIDE = 32;

    // ------------------------------------------------------------
    // timing in cycles and reset vector address
    // ------------------------------------------------------------
    localparam int DELAY_FAST_CYCLES = 512;
    localparam int DELAY_SLOW_CYCLES = 256;
    localparam int FETCH_CYCLES = 2;
    localparam int SLOW_SETTLE_CYCLES = 3;
    localparam int FAST_SETTLE_CYCLES = 8;
    localparam logic [15:0] RESET_VECTOR_ADDR = 16'hFFFE;

    typedef enum logic [3:0] {
        SEQ_ACTIVE = 4'b0001,
        SEQ_DELAY = 4'b0010,
        SEQ_FETCH = 4'b0100,
        SEQ_RUN = 4'b1000
    } seq_state_t;

    typedef enum logic [3:0] {
        SW_FAST = 4'b0001,
        SW_TO_SLOW = 4'b0010,
        SW_SLOW = 4'b0100,
        SW_TO_FAST = 4'b1000
    } sw_state_t;

endpackage

// ===== design/clock_divider.sv
`timescale 1ns/1ps

// ------------------------------------------------------------
// enable-pulse divider: tick every 2^min(shiftSel, WIDTH) cycles
// ------------------------------------------------------------
module clock_divider
    import clock_reset_pkg::*;
#(
    parameter int WIDTH = 5
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // control
    input wire logic [2:0] shiftSel,
    // result
    output logic tick
);

    logic [WIDTH-1:0] count_r;
    logic [WIDTH-1:0] mask;

    always_comb
    begin
        mask = WIDTH'((32'h1 << shiftSel) - 32'h1);
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            count_r <= '0;
        else
            count_r <= count_r + 1'b1;
    end

    // shiftSel zero gives a tick every cycle
    assign tick = ((count_r & mask) == mask);

endmodule

// ===== design/clock_reset_ctrl.sv
`timescale 1ns/1ps

module clock_reset_ctrl
    import clock_reset_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [9:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // reset sources, supply warning (unused) and clock option
    input wire logic resetPinIn,
    input wire logic underVoltage,
    input wire logic watchdogUnderflow,
    input wire logic illegalOpcode,
    input wire logic supplyWarning,
    input wire logic externalClockOption,
    // reset pin open drain
    output logic resetPinOut,
    output logic resetPinOe_n,
    // oscillator controls
    input wire logic slowOscEdge,
    input wire logic fastOscEdge,
    output logic [9:0] oscTrim,
    output logic fastOscEnable,
    output logic slowOscEnable,
    // clocks out
    output logic cpuClockTick,
    output logic clockOutEnable,
    output logic clockOutPin,
    // sequencer out
    output logic coreReset,
    output logic vectorFetch,
    output logic [15:0] vectorAddr
);

    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    logic slowDivide_r;
    logic clockOut_r;
    logic [7:0] trimHigh_r;
    logic [1:0] trimLow_r;
    logic uvFlag_r;
    logic swIrqEn_r;
    logic [2:0] prescale_r;
    logic [1:0] threshold_r;
    logic srcSelect_r;
    logic slowReady_r;
    logic fastReady_r;
    logic lastReset_r;
    sw_state_t swState_r;
    seq_state_t seqState_r;
    logic [9:0] delayCnt_r;
    logic [1:0] fetchCnt_r;
    logic [3:0] settleCnt_r;
    logic [2:0] pinSync_r;
    logic [1:0] slowEdgeSync_r;
    logic [1:0] fastEdgeSync_r;
    logic [1:0] uvSync_r;
    logic [2:0] pinMask_r;
    logic slowEdgePrev_r;
    logic fastEdgePrev_r;
    logic [9:0] delayLimit;

    logic wbWrite;
    logic anySource;
    logic slowPulse;
    logic fastPulse;
    logic oscTick;
    logic slowTick;
    logic [4:0] slowCnt_r;
    logic [2:0] preShift;

    assign wbWrite = cyc_i && stb_i && we_i && sel_i[0] && ack_o;

    // ------------------------------------------------------------
    // bus answer: one wait state, ack drops next cycle
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst)
            ack_o <= 1'b0;
        else
            ack_o <= cyc_i && stb_i && !ack_o;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            dat_o <= 32'h0;
        else if (cyc_i && stb_i && !ack_o)
        begin
            case (adr_i)
                ADDR_MAIN_CLOCK_CTRL:
                    dat_o <= {30'h0, clockOut_r, slowDivide_r};
                ADDR_OSC_TRIM_HIGH:
                    dat_o <= {24'h0, trimHigh_r};
                ADDR_INTEGRITY:
                    dat_o <= {25'h0, trimLow_r, 2'b00, uvFlag_r, uvSync_r[1], swIrqEn_r};
                ADDR_PRESCALE_THRESH:
                    dat_o <= {24'h0, prescale_r, 3'b000, threshold_r};
                ADDR_CLOCK_SWITCH:
                    dat_o <= {28'h0, slowReady_r, fastReady_r, 1'b0, srcSelect_r};
                ADDR_RESET_STATUS:
                    dat_o <= {27'h0, delayLimit == 10'(DELAY_SLOW_CYCLES - 1), seqState_r};
                default:
                    dat_o <= 32'h0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // main clock control
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst || coreReset)
        begin
            slowDivide_r <= RST_MAIN_CLOCK_CTRL[BIT_SLOW_DIVIDE];
            clockOut_r <= RST_MAIN_CLOCK_CTRL[BIT_CLOCK_OUT];
        end
        else if (wbWrite && adr_i == ADDR_MAIN_CLOCK_CTRL)
        begin
            slowDivide_r <= dat_i[BIT_SLOW_DIVIDE];
            clockOut_r <= dat_i[BIT_CLOCK_OUT];
        end
    end

    // ------------------------------------------------------------
    // trim, integrity and prescale registers
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst || coreReset)
        begin
            trimHigh_r <= RST_OSC_TRIM_HIGH;
            trimLow_r <= RST_TRIM_LOWER;
            swIrqEn_r <= 1'b0;
            prescale_r <= RST_PRESCALE;
            threshold_r <= RST_THRESHOLD;
        end
        else if (wbWrite)
        begin
            if (adr_i == ADDR_OSC_TRIM_HIGH)
                trimHigh_r <= dat_i[7:0];
            if (adr_i == ADDR_INTEGRITY)
            begin
                trimLow_r <= dat_i[LSB_TRIM_LOWER +: 2];
                swIrqEn_r <= dat_i[BIT_SW_IRQ_EN];
            end
            if (adr_i == ADDR_PRESCALE_THRESH)
            begin
                prescale_r <= dat_i[LSB_PRESCALE +: 3];
                threshold_r <= dat_i[1:0];
            end
        end
    end

    // larger code means slower oscillator; analog side decodes it
    assign oscTrim = {trimHigh_r, trimLow_r};

    // undervoltage flag tracks the source of the latest reset
    always_ff @(posedge clk)
    begin
        if (rst)
            lastReset_r <= 1'b0;
        else if (uvSync_r[1])
            lastReset_r <= 1'b1;
        else if (anySource)
            lastReset_r <= 1'b0;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            uvFlag_r <= 1'b0;
        else if (seqState_r == SEQ_ACTIVE)
            uvFlag_r <= lastReset_r || uvSync_r[1];
    end

    // ------------------------------------------------------------
    // synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            slowEdgeSync_r <= 2'b00;
            fastEdgeSync_r <= 2'b00;
            uvSync_r <= 2'b00;
            pinMask_r <= 3'h7;
            slowEdgePrev_r <= 1'b0;
            fastEdgePrev_r <= 1'b0;
        end
        else
        begin
            slowEdgeSync_r <= {slowEdgeSync_r[0], slowOscEdge};
            fastEdgeSync_r <= {fastEdgeSync_r[0], fastOscEdge};
            uvSync_r <= {uvSync_r[0], underVoltage};
            pinMask_r <= {pinMask_r[1:0], !resetPinOe_n};
            slowEdgePrev_r <= slowEdgeSync_r[1];
            fastEdgePrev_r <= fastEdgeSync_r[1];
        end
    end

    assign slowPulse = slowEdgeSync_r[1] && !slowEdgePrev_r;
    assign fastPulse = fastEdgeSync_r[1] && !fastEdgePrev_r;

    // reset pin low is caught with no clock; release is synchronised
    always_ff @(posedge clk or negedge resetPinIn)
    begin
        if (!resetPinIn)
            pinSync_r <= 3'b000;
        else
            pinSync_r <= {pinSync_r[1:0], 1'b1};
    end

    // ------------------------------------------------------------
    // oscillator switch handshake
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst || coreReset)
        begin
            srcSelect_r <= RST_SOURCE_SELECT;
            swState_r <= SW_SLOW;
            slowReady_r <= 1'b1;
            fastReady_r <= 1'b0;
            settleCnt_r <= 4'h0;
        end
        else
        begin
            if (wbWrite && adr_i == ADDR_CLOCK_SWITCH)
                srcSelect_r <= dat_i[BIT_SRC_SELECT];
            case (swState_r)
                SW_FAST:
                    if (srcSelect_r)
                    begin
                        fastReady_r <= 1'b0;
                        settleCnt_r <= 4'h0;
                        swState_r <= SW_TO_SLOW;
                    end
                SW_TO_SLOW:
                    if (slowPulse)
                    begin
                        settleCnt_r <= settleCnt_r + 1'b1;
                        if (settleCnt_r == 4'(SLOW_SETTLE_CYCLES - 1))
                        begin
                            slowReady_r <= 1'b1;
                            swState_r <= SW_SLOW;
                        end
                    end
                SW_SLOW:
                    if (!srcSelect_r)
                    begin
                        settleCnt_r <= 4'h0;
                        swState_r <= SW_TO_FAST;
                    end
                SW_TO_FAST:
                    if (fastPulse)
                    begin
                        settleCnt_r <= settleCnt_r + 1'b1;
                        if (settleCnt_r == 4'(FAST_SETTLE_CYCLES - 1))
                        begin
                            slowReady_r <= 1'b0;
                            fastReady_r <= 1'b1;
                            swState_r <= SW_FAST;
                        end
                    end
                default:
                    swState_r <= SW_SLOW;
            endcase
        end
    end

    // old oscillator runs until the switch completes
    assign fastOscEnable = (swState_r != SW_SLOW) || externalClockOption;
    assign slowOscEnable = (swState_r != SW_FAST) || externalClockOption;

    // ------------------------------------------------------------
    // clock division
    // ------------------------------------------------------------
    always_comb
    begin
        case (prescale_r)
            PRE_DIV2: preShift = 3'h1;
            PRE_DIV4: preShift = 3'h2;
            PRE_DIV8: preShift = 3'h3;
            PRE_DIV16: preShift = 3'h4;
            default: preShift = 3'h0;
        endcase
    end

    clock_divider #(
        .WIDTH(4)
    ) u_prescale (
        .clk(clk),
        .rst(rst),
        .shiftSel(preShift),
        .tick(oscTick)
    );

    // slow mode: one cpu tick every 32 oscillator ticks
    always_ff @(posedge clk)
    begin
        if (rst)
            slowCnt_r <= 5'h0;
        else if (oscTick)
            slowCnt_r <= slowCnt_r + 1'b1;
    end

    assign slowTick = oscTick && (slowCnt_r == 5'(SLOW_DIVIDE - 1));
    assign cpuClockTick = slowDivide_r ? slowTick : oscTick;
    assign clockOutEnable = clockOut_r;
    assign clockOutPin = clockOut_r && cpuClockTick;

    // ------------------------------------------------------------
    // reset sequencer
    // ------------------------------------------------------------
    // pin reads back our own pull; ignored until its release has synchronised
    assign anySource = (!pinSync_r[2] && resetPinOe_n && pinMask_r == 3'h0)
        || uvSync_r[1] || watchdogUnderflow || illegalOpcode;
    assign delayLimit = (srcSelect_r && !externalClockOption)
        ? 10'(DELAY_SLOW_CYCLES - 1) : 10'(DELAY_FAST_CYCLES - 1);

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            seqState_r <= SEQ_ACTIVE;
            delayCnt_r <= 10'h0;
            fetchCnt_r <= 2'h0;
        end
        else if (anySource)
        begin
            seqState_r <= SEQ_ACTIVE;
            delayCnt_r <= 10'h0;
            fetchCnt_r <= 2'h0;
        end
        else
        begin
            case (seqState_r)
                SEQ_ACTIVE:
                    seqState_r <= SEQ_DELAY;
                SEQ_DELAY:
                    if (delayCnt_r == delayLimit)
                        seqState_r <= SEQ_FETCH;
                    else
                        delayCnt_r <= delayCnt_r + 1'b1;
                SEQ_FETCH:
                    if (fetchCnt_r == 2'(FETCH_CYCLES - 1))
                        seqState_r <= SEQ_RUN;
                    else
                        fetchCnt_r <= fetchCnt_r + 1'b1;
                SEQ_RUN:
                    seqState_r <= SEQ_RUN;
                default:
                    seqState_r <= SEQ_ACTIVE;
            endcase
        end
    end

    assign coreReset = (seqState_r == SEQ_ACTIVE) || (seqState_r == SEQ_DELAY);
    assign vectorFetch = (seqState_r == SEQ_FETCH);
    assign vectorAddr = RESET_VECTOR_ADDR + 16'(fetchCnt_r);

    // open drain: only ever pulls low, enable low while pulling
    assign resetPinOut = 1'b0;
    assign resetPinOe_n = !(coreReset || uvSync_r[1]);

endmodule

// ===== bench/clock_reset_ctrl_props.sv
`timescale 1ns/1ps

// ------------------------------------------------------------
// port checker
// ------------------------------------------------------------
module clock_reset_ctrl_props
    import clock_reset_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // bus
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic ack_o,
    // reset sources and pin
    input wire logic resetPinIn,
    input wire logic underVoltage,
    input wire logic watchdogUnderflow,
    input wire logic illegalOpcode,
    input wire logic resetPinOut,
    input wire logic resetPinOe_n,
    // clocks and sequencer
    input wire logic cpuClockTick,
    input wire logic clockOutEnable,
    input wire logic clockOutPin,
    input wire logic coreReset,
    input wire logic vectorFetch,
    input wire logic [15:0] vectorAddr
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // saturates so a stuck reset cannot wrap past the bound
    logic [9:0] runLen_r;
    always_ff @(posedge clk)
    begin
        if (rst || !coreReset)
            runLen_r <= 10'h000;
        else if (runLen_r != 10'h3FF)
            runLen_r <= runLen_r + 10'h001;
    end

    sequence fetchLow_s;
        vectorFetch && vectorAddr == RESET_VECTOR_ADDR;
    endsequence
    sequence fetchHigh_s;
        vectorFetch && vectorAddr == 16'hFFFF;
    endsequence

    bus_answer_a : assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("ack missing after request");
    pin_zero_a : assert property (!resetPinOe_n |-> !resetPinOut)
        else $error("reset pin driven high");
    pin_hold_a : assert property (coreReset |-> !resetPinOe_n)
        else $error("reset pin released during reset");
    uv_pin_a : assert property (underVoltage && $past(underVoltage) &&
        $past(underVoltage, 2) && $past(underVoltage, 3) |-> !resetPinOe_n)
        else $error("undervoltage not driving pin");
    src_reset_a : assert property (watchdogUnderflow || illegalOpcode |=> coreReset)
        else $error("internal source gave no reset");
    pin_async_a : assert property (!resetPinIn |-> ##[0:2] coreReset)
        else $error("low pin gave no reset");
    fetch_vector_a : assert property ($rose(vectorFetch) |->
        fetchLow_s ##1 fetchHigh_s ##1 !vectorFetch)
        else $error("vector fetch wrong");
    fetch_after_a : assert property ($fell(coreReset) |-> vectorFetch)
        else $error("no fetch after delay");
    delay_min_a : assert property ($fell(coreReset) |-> runLen_r >= 10'h100)
        else $error("delay phase too short");
    clkout_gate_a : assert property (clockOutPin |-> clockOutEnable && cpuClockTick)
        else $error("clock out while disabled");
endmodule

bind clock_reset_ctrl clock_reset_ctrl_props u_clock_reset_ctrl_props (.clk, .rst, .cyc_i,
    .stb_i, .ack_o, .resetPinIn, .underVoltage, .watchdogUnderflow, .illegalOpcode,
    .resetPinOut, .resetPinOe_n, .cpuClockTick, .clockOutEnable, .clockOutPin, .coreReset,
    .vectorFetch, .vectorAddr);

// ===== bench/osc_reset_partner.sv
`timescale 1ns/1ps

// ------------------------------------------------------------
// oscillators and external reset circuit
// ------------------------------------------------------------
module osc_reset_partner
(
    // clock
    input wire logic clk,
    // oscillator enables
    input wire logic fastOscEnable,
    input wire logic slowOscEnable,
    // reset pin
    input wire logic resetPinOut,
    input wire logic resetPinOe_n,
    input wire logic extPullLow,
    // outputs
    output logic fastOscEdge,
    output logic slowOscEdge,
    output logic resetPinLevel
);
    logic [3:0] phase_r = 4'h0;
    always_ff @(posedge clk)
        phase_r <= phase_r + 4'h1;
    // a stopped oscillator stays low, so no edge reaches the settle counters
    assign fastOscEdge = fastOscEnable & phase_r[1];
    assign slowOscEdge = slowOscEnable & phase_r[3];
    // weak pull-up; either party may only pull low
    assign resetPinLevel = !((!resetPinOe_n && !resetPinOut) || extPullLow);
endmodule

// ===== bench/tb.sv
`timescale 1ns/1ps

module tb;
    import clock_reset_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
    logic [9:0] adr_i = 10'h000;
    logic [31:0] dat_i = 32'h0, dat_o;
    logic ack_o, resetPinIn, resetPinOut, resetPinOe_n, fastOscEdge, slowOscEdge;
    logic underVoltage = 1'b0, watchdogUnderflow = 1'b0, illegalOpcode = 1'b0;
    logic extPull = 1'b0, extClock = 1'b0;
    logic [9:0] oscTrim;
    logic fastOscEnable, slowOscEnable, cpuClockTick, clockOutEnable, clockOutPin;
    logic coreReset, vectorFetch;
    logic [15:0] vectorAddr;
    int bad_count = 0, num_checks = 0, cycles = 0, tickCnt = 0;

    always #2 clk = ~clk;

    clock_reset_ctrl u_clock_reset_ctrl (.clk, .rst, .cyc_i, .stb_i, .we_i, .adr_i,
        .sel_i(4'hF), .dat_i, .dat_o, .ack_o, .resetPinIn, .underVoltage,
        .watchdogUnderflow, .illegalOpcode, .supplyWarning(1'b0), .externalClockOption(extClock),
        .resetPinOut, .resetPinOe_n, .slowOscEdge, .fastOscEdge, .oscTrim, .fastOscEnable,
        .slowOscEnable, .cpuClockTick, .clockOutEnable, .clockOutPin, .coreReset,
        .vectorFetch, .vectorAddr);
    osc_reset_partner u_osc_reset_partner (.clk, .fastOscEnable, .slowOscEnable,
        .resetPinOut, .resetPinOe_n, .extPullLow(extPull), .fastOscEdge, .slowOscEdge,
        .resetPinLevel(resetPinIn));

    always @(posedge clk)
    begin
        cycles++;
        if (cpuClockTick === 1'b1)
            tickCnt++;
        if (cycles == 30000)
        begin
            bad_count++;
            wrap_up();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wb(input logic w, input logic [9:0] a, input logic [7:0] d,
        output logic [7:0] q);
        int n;
        n = 0;
        @(posedge clk);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= {24'h000000, d};
        do
        begin
            @(posedge clk);
            n++;
        end while (ack_o !== 1'b1 && n < 50);
        q = dat_o[7:0];
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        check(n < 50, 1'b1);
    endtask

    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        logic [7:0] q;
        wb(1'b1, a, d, q);
    endtask

    task automatic rd_chk(input logic [9:0] a, input logic [7:0] m, input logic [7:0] e);
        logic [7:0] q;
        wb(1'b0, a, 8'h00, q);
        check(q & m, e);
    endtask

    task automatic wait_run;
        int n;
        n = 0;
        while ((coreReset !== 1'b0 || vectorFetch !== 1'b0) && n < 3000)
        begin
            @(posedge clk);
            n++;
        end
        check(n < 3000, 1'b1);
    endtask

    task automatic t_regs;
        rd_chk(ADDR_MAIN_CLOCK_CTRL, 8'hFF, 8'h00);
        rd_chk(ADDR_OSC_TRIM_HIGH, 8'hFF, 8'hFF);
        rd_chk(ADDR_INTEGRITY, 8'hFB, 8'h00);
        rd_chk(ADDR_PRESCALE_THRESH, 8'hFF, 8'h03);
        rd_chk(ADDR_CLOCK_SWITCH, 8'hFF, 8'h09);
        rd_chk(ADDR_RESET_STATUS, 8'h1F, 8'h18);
        wr(10'h0C0, 8'h5A);
        rd_chk(10'h0C0, 8'hFF, 8'h00);
        check(oscTrim, 10'h3FC);
        wr(ADDR_OSC_TRIM_HIGH, 8'h80);
        wr(ADDR_INTEGRITY, 8'h60);
        @(posedge clk);
        check(oscTrim, {8'h80, 2'b11});
        rd_chk(ADDR_INTEGRITY, 8'h60, 8'h60);
        for (int c = 0; c < 8; c++)
        begin
            wr(ADDR_PRESCALE_THRESH, {c[2:0], 5'h03});
            rd_chk(ADDR_PRESCALE_THRESH, 8'hFF, {c[2:0], 5'h03});
        end
        $display("registers test done");
    endtask

    task automatic t_clock;
        int n0, n1;
        wr(ADDR_MAIN_CLOCK_CTRL, 8'h00);
        n0 = tickCnt;
        repeat (640) @(posedge clk);
        n0 = tickCnt - n0;
        wr(ADDR_MAIN_CLOCK_CTRL, 8'h03);
        n1 = tickCnt;
        repeat (640) @(posedge clk);
        n1 = tickCnt - n1;
        check(n1 > 0 && n0 >= 32 * (n1 - 1) && n0 <= 32 * (n1 + 1), 1'b1);
        check(clockOutEnable, 1'b1);
        rd_chk(ADDR_MAIN_CLOCK_CTRL, 8'hFF, 8'h03);
        wr(ADDR_MAIN_CLOCK_CTRL, 8'h00);
        @(posedge clk);
        check(clockOutEnable, 1'b0);
        wr(ADDR_PRESCALE_THRESH, {PRE_DIV4, 5'h03});
        n0 = tickCnt;
        repeat (640) @(posedge clk);
        n0 = tickCnt - n0;
        check(n0 >= 159 && n0 <= 161, 1'b1);
        $display("clock test done");
    endtask

    // second source mid-delay must restart the count
    task automatic src_reset(input logic restart, input logic ext);
        int n;
        int lim;
        lim = ext ? DELAY_FAST_CYCLES : DELAY_SLOW_CYCLES;
        @(posedge clk);
        watchdogUnderflow <= 1'b1;
        extClock <= ext;
        @(posedge clk);
        watchdogUnderflow <= 1'b0;
        if (restart)
        begin
            repeat (100) @(posedge clk);
            illegalOpcode <= 1'b1;
            @(posedge clk);
            illegalOpcode <= 1'b0;
        end
        n = 0;
        while (vectorFetch !== 1'b1 && n < 2000)
        begin
            @(posedge clk);
            n++;
        end
        check(n >= lim + 1 && n <= lim + 3, 1'b1);
        wait_run();
        rd_chk(ADDR_OSC_TRIM_HIGH, 8'hFF, 8'hFF);
        rd_chk(ADDR_RESET_STATUS, 8'h1F, ext ? 8'h08 : 8'h18);
        extClock <= 1'b0;
        $display("source reset test done");
    endtask

    task automatic poll(input logic [7:0] e);
        logic [7:0] q;
        int n;
        n = 0;
        do
        begin
            wb(1'b0, ADDR_CLOCK_SWITCH, 8'h00, q);
            n++;
        end while (q !== e && n < 100);
        check(q, e);
    endtask

    task automatic t_switch;
        wr(ADDR_CLOCK_SWITCH, 8'h00);
        poll(8'h04);
        repeat (20) @(posedge clk);
        check({fastOscEnable, slowOscEnable}, 2'b10);
        wr(ADDR_CLOCK_SWITCH, 8'h01);
        poll(8'h09);
        repeat (20) @(posedge clk);
        check({fastOscEnable, slowOscEnable}, 2'b01);
        $display("switch test done");
    endtask

    task automatic t_pins;
        underVoltage <= 1'b1;
        repeat (10) @(posedge clk);
        check(resetPinOe_n, 1'b0);
        underVoltage <= 1'b0;
        wait_run();
        rd_chk(ADDR_INTEGRITY, 8'h04, 8'h04);
        extPull <= 1'b1;
        repeat (5) @(posedge clk);
        check(coreReset, 1'b1);
        extPull <= 1'b0;
        wait_run();
        rd_chk(ADDR_INTEGRITY, 8'h04, 8'h00);
        $display("pin test done");
    endtask

    task automatic wrap_up;
        $display("checks=%0d mismatches=%0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial
    begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        wait_run();
        t_regs();
        t_clock();
        src_reset(1'b0, 1'b0);
        src_reset(1'b1, 1'b1);
        t_switch();
        t_pins();
        wrap_up();
    end
endmodule
